// ==== logic/dme_pkg.sv ====
/*
 * Constants shared by the debug-state entry controller.
 * Assumes one system clock at 250 MHz and an active-low asynchronous reset.
 */
// Summary of operation
// - In the debug state the core's instruction fetch is stopped, except for instructions the debugger injects.
// - In the debug state the system clock keeps running and is gated only when stop mode is in effect.
// - Enabled peripherals keep running during the debug state unless stop mode is in effect.
// - If the core is in halt mode when the debug state is entered, halt is left with no software action.
// - While in the debug state with the watchdog enabled, the watchdog is refreshed every cycle.
// - The debug state is entered as soon as the core completes a breakpoint instruction.
// - On larger packages the debug pin is sampled in the last reset cycle and a low level enters the debug state at once.
`default_nettype none
package dme_pkg;
    // Debugger must hold the pin low this many cycles after reset
    localparam int unsigned DME_PIN_HOLD_CYCLES = 5000;
    // Reset value of the debug state flag
    localparam logic DME_DEBUG_RST = 1'b0;
    // Reset value of the halt flag
    localparam logic DME_HALT_RST = 1'b0;
    // Reset value of the registered reset request; reset counts as held
    localparam logic DME_SYS_RESET_SEEN_RST = 1'b1;
    // Reset value of the captured strap
    localparam logic DME_STRAP_RST = 1'b0;
    // Reset value of the resume pulse
    localparam logic DME_RESUME_RST = 1'b0;

    typedef enum logic [1:0] {
        DME_ST_RESET,
        DME_ST_RUN,
        DME_ST_DEBUG
    } dme_state_e;
endpackage
`default_nettype wire

// ==== logic/dme_entry_sampler.sv ====
/*
 * Debug pin strap sampler.
 * Catches the debug pin level on the last clock cycle of system reset, that is
 * the cycle before the one in which the synchronous reset request falls.
 */
`timescale 1ns/100ps
`default_nettype none
module dme_entry_sampler
    import dme_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Reset sequencing
    input wire logic sys_reset,
    input wire logic large_package,
    input wire logic debug_pin,
    // Result
    output logic strap_debug
);
    logic sys_reset_q;
    logic strap_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sys_reset_q <= DME_SYS_RESET_SEEN_RST;
        end else begin
            sys_reset_q <= sys_reset;
        end
    end

    // Sample only while reset is held; the value frozen is the last reset cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_q <= DME_STRAP_RST;
        end else if (sys_reset) begin
            strap_q <= large_package && !debug_pin;
        end
    end

    // One-cycle pulse on the first cycle out of reset
    assign strap_debug = strap_q && sys_reset_q && !sys_reset;
endmodule // dme_entry_sampler
`default_nettype wire

// ==== logic/dme_debug_ctrl.sv ====
/*
 * Debug state entry and behaviour controller.
 * Assumes the core reports breakpoint completion as a one-cycle pulse, the
 * debugger interface gives exit and injected-instruction strobes, and all
 * inputs are synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module dme_debug_ctrl
    import dme_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Reset and package strap
    input wire logic sys_reset,
    input wire logic large_package,
    input wire logic debug_pin,
    // Core status
    input wire logic breakpoint_done,
    input wire logic halt_enter,
    input wire logic halt_wake,
    input wire logic stop_mode,
    input wire logic wdt_enable,
    // Onchip debugger commands
    input wire logic dbg_exec_req,
    input wire logic dbg_exit_req,
    // Core and system controls
    output logic fetch_enable,
    output logic halt_active,
    output logic sysclk_enable,
    output logic periph_enable,
    output logic wdt_refresh,
    output logic debug_active,
    output logic resume_pulse
);
    dme_state_e state_q;
    dme_state_e state_d;
    logic halt_q;
    logic resume_q;
    logic strap_debug;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic in_debug(input dme_state_e s);
        return s == DME_ST_DEBUG;
    endfunction

    function automatic logic in_run(input dme_state_e s);
        return s == DME_ST_RUN;
    endfunction

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    dme_entry_sampler u_sampler (
        .clk(clk),
        .rstn(rstn),
        .sys_reset(sys_reset),
        .large_package(large_package),
        .debug_pin(debug_pin),
        .strap_debug(strap_debug)
    );

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            DME_ST_RESET: begin
                if (!sys_reset) begin
                    state_d = strap_debug ? DME_ST_DEBUG : DME_ST_RUN;
                end
            end
            DME_ST_RUN: begin
                if (breakpoint_done) begin
                    state_d = DME_ST_DEBUG;
                end
            end
            DME_ST_DEBUG: begin
                // Breakpoints executed on debugger request do not re-enter
                if (dbg_exit_req) begin
                    state_d = DME_ST_RUN;
                end
            end
            default: begin
                state_d = DME_ST_RESET;
            end
        endcase
        if (sys_reset) begin
            state_d = DME_ST_RESET;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= DME_ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Halt tracking
    // ------------------------------------------------------------
    // Entering debug wins over a halt request in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            halt_q <= DME_HALT_RST;
        end else if (sys_reset || in_debug(state_d)) begin
            halt_q <= 1'b0;
        end else if (halt_enter) begin
            halt_q <= 1'b1;
        end else if (halt_wake) begin
            // A wake landing with a new halt loses, so the new halt is kept
            halt_q <= 1'b0;
        end
    end

    // Resume pulse: the core restarts fetch at its current program counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resume_q <= DME_RESUME_RST;
        end else begin
            resume_q <= in_debug(state_q) && in_run(state_d);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign debug_active = in_debug(state_q);
    assign halt_active = halt_q;
    assign fetch_enable = (in_run(state_q) && !halt_q)
                        || (debug_active && dbg_exec_req);
    assign sysclk_enable = !stop_mode;
    assign periph_enable = !stop_mode;
    assign wdt_refresh = debug_active && wdt_enable;
    assign resume_pulse = resume_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence bp_seq;
        (state_q == DME_ST_RUN) && breakpoint_done && !sys_reset;
    endsequence

    sequence exit_seq;
        debug_active && dbg_exit_req && !sys_reset;
    endsequence

    sequence bp_in_debug_seq;
        debug_active && breakpoint_done && !dbg_exit_req && !sys_reset;
    endsequence

    sequence no_strap_seq;
        $fell(sys_reset) && !($past(large_package) && !$past(debug_pin));
    endsequence

    sequence resume_seq;
        resume_pulse && !halt_active;
    endsequence

    fetch_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        debug_active && !dbg_exec_req |-> !fetch_enable)
        else $error("fetch running in debug state");
    clock_runs_a: assert property (@(posedge clk) disable iff (!rstn)
        debug_active && !stop_mode |-> sysclk_enable)
        else $error("clock stopped in debug state");
    periph_runs_a: assert property (@(posedge clk) disable iff (!rstn)
        debug_active && !stop_mode |-> periph_enable)
        else $error("peripherals stopped in debug state");
    halt_exit_a: assert property (@(posedge clk) disable iff (!rstn)
        bp_seq |=> !halt_active && debug_active)
        else $error("halt kept on debug entry");
    wdt_refresh_a: assert property (@(posedge clk) disable iff (!rstn)
        debug_active && wdt_enable |-> wdt_refresh)
        else $error("watchdog not refreshed");
    bp_entry_a: assert property (@(posedge clk) disable iff (!rstn)
        bp_seq |=> debug_active)
        else $error("breakpoint did not enter debug");
    strap_entry_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(sys_reset) && large_package && !$past(debug_pin) |=> debug_active)
        else $error("strap did not enter debug");
    debug_exit_a: assert property (@(posedge clk) disable iff (!rstn)
        exit_seq |=> !debug_active ##0 resume_pulse)
        else $error("exit not honoured");
    debug_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        debug_active && !dbg_exit_req && !sys_reset |=> debug_active)
        else $error("left debug without command");

    // ------------------------------------------------------------
    // Refusals and quiet outputs
    // ------------------------------------------------------------
    bp_refused_a: assert property (@(posedge clk) disable iff (!rstn)
        bp_in_debug_seq |=> debug_active && !resume_pulse)
        else $error("breakpoint in debug state disturbed it");
    strap_refused_a: assert property (@(posedge clk) disable iff (!rstn)
        no_strap_seq |=> !debug_active)
        else $error("debug entered without strap");
    reset_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        sys_reset |=> !debug_active && !halt_active && !fetch_enable)
        else $error("core active during reset");
    debug_no_halt_a: assert property (@(posedge clk) disable iff (!rstn)
        debug_active |-> !halt_active)
        else $error("halt held in debug state");
    resume_after_a: assert property (@(posedge clk) disable iff (!rstn)
        resume_pulse |-> !debug_active && $past(debug_active))
        else $error("resume without debug exit");
    resume_fetch_a: assert property (@(posedge clk) disable iff (!rstn)
        resume_seq |-> fetch_enable)
        else $error("fetch not restarted on resume");
    exec_fetch_a: assert property (@(posedge clk) disable iff (!rstn)
        debug_active && dbg_exec_req |-> fetch_enable)
        else $error("injected instruction not fetched");
    wdt_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        !debug_active |-> !wdt_refresh)
        else $error("watchdog refreshed outside debug");
    clock_stop_a: assert property (@(posedge clk) disable iff (!rstn)
        stop_mode |-> !sysclk_enable && !periph_enable)
        else $error("clock running in stop mode");
endmodule // dme_debug_ctrl
`default_nettype wire

// ==== verif/dme_host_model.sv ====
/*
 * Debugger host model: drives the debug pin of the device.
 * Assumes clk, rstn and sys_reset are those of the device under test.
 */
`timescale 1ns/100ps
`default_nettype none
module dme_host_model
    import dme_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic sys_reset,
    // Request and pin
    input wire logic want_debug,
    output logic debug_pin
);
    // ----------------
    // Pin hold
    // ----------------
    int unsigned hold_q;
    // Low is kept past reset so the pin is not read as a baud sequence
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_q <= 0;
        end else if (sys_reset) begin
            hold_q <= DME_PIN_HOLD_CYCLES;
        end else if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end
    end
    // Pin idles high through its pull-up once released
    assign debug_pin = !(want_debug && (sys_reset || hold_q != 0));
endmodule // dme_host_model
`default_nettype wire

// ==== verif/tb_debug_mode_entry_control.sv ====
/*
 * Self-checking bench for the debug state controller.
 * Assumes a 250 MHz clock and the host model on the debug pin.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_debug_mode_entry_control;
    import dme_pkg::*;
    logic clk = 0, rstn = 0, sys_reset = 1, large_package = 0, want_debug = 0;
    logic breakpoint_done = 0, halt_enter = 0, stop_mode = 0, wdt_enable = 0, halt_wake = 0;
    logic dbg_exec_req = 0, dbg_exit_req = 0, debug_pin, fetch_enable, halt_active;
    logic sysclk_enable, periph_enable, wdt_refresh, debug_active, resume_pulse;
    int err_count = 0, samples_checked = 0, seed;
    initial forever #2 clk = ~clk;
    dme_host_model host (.clk(clk), .rstn(rstn), .sys_reset(sys_reset),
        .want_debug(want_debug), .debug_pin(debug_pin));
    dme_debug_ctrl uut (.clk(clk), .rstn(rstn), .sys_reset(sys_reset),
        .large_package(large_package), .debug_pin(debug_pin),
        .breakpoint_done(breakpoint_done), .halt_enter(halt_enter), .halt_wake(halt_wake),
        .stop_mode(stop_mode), .wdt_enable(wdt_enable), .dbg_exec_req(dbg_exec_req),
        .dbg_exit_req(dbg_exit_req), .fetch_enable(fetch_enable),
        .halt_active(halt_active), .sysclk_enable(sysclk_enable),
        .periph_enable(periph_enable), .wdt_refresh(wdt_refresh),
        .debug_active(debug_active), .resume_pulse(resume_pulse));
    // ----------------
    // Checking and tasks
    // ----------------
    task automatic chk(input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Strap enters debug only on a large package with the pin low
    function automatic logic exp_strap(input logic lp, input logic want);
        return lp & want;
    endfunction
    // In debug only injected instructions fetch; in run a halt stops fetch
    function automatic logic exp_fetch(input logic in_dbg, input logic halted,
                                       input logic exec);
        return in_dbg ? exec : !halted;
    endfunction
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic leave();
        @(posedge clk);
        dbg_exit_req <= 1'b1;
        @(posedge clk);
        dbg_exit_req <= 1'b0;
        #1;
        chk(debug_active, 1'b0);
        chk(resume_pulse, 1'b1);
        chk(fetch_enable, 1'b1);
    endtask
    // Strap is taken in the last cycle with sys_reset high
    task automatic strap(input logic lp, input logic want);
        @(posedge clk);
        sys_reset <= 1'b1;
        large_package <= lp;
        want_debug <= want;
        repeat (3) @(posedge clk);
        sys_reset <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(debug_active, exp_strap(lp, want));
        chk(fetch_enable, exp_fetch(exp_strap(lp, want), 1'b0, 1'b0));
        $display("strap test done lp=%0d want=%0d", lp, want);
    endtask
    // Corners: refused exit, halt set beating wake, refused and back-to-back
    // breakpoints, then a reset out of the debug state into a strap entry
    task automatic corners();
        @(posedge clk);
        dbg_exec_req <= 1'b0;
        dbg_exit_req <= 1'b1;
        @(posedge clk);
        dbg_exit_req <= 1'b0;
        halt_enter <= 1'b1;
        halt_wake <= 1'b1;
        #1;
        chk(debug_active, 1'b0);
        chk(resume_pulse, 1'b0);
        @(posedge clk);
        halt_enter <= 1'b0;
        #1;
        chk(halt_active, 1'b1);
        chk(fetch_enable, exp_fetch(1'b0, 1'b1, 1'b0));
        @(posedge clk);
        halt_wake <= 1'b0;
        breakpoint_done <= 1'b1;
        #1;
        chk(halt_active, 1'b0);
        @(posedge clk);
        #1;
        chk(debug_active, 1'b1);
        @(posedge clk);
        breakpoint_done <= 1'b0;
        dbg_exit_req <= 1'b1;
        #1;
        chk(debug_active, 1'b1);
        chk(resume_pulse, 1'b0);
        @(posedge clk);
        dbg_exit_req <= 1'b0;
        breakpoint_done <= 1'b1;
        #1;
        chk(debug_active, 1'b0);
        chk(resume_pulse, 1'b1);
        @(posedge clk);
        breakpoint_done <= 1'b0;
        #1;
        chk(debug_active, 1'b1);
        chk(resume_pulse, 1'b0);
        @(posedge clk);
        rstn <= 1'b0;
        sys_reset <= 1'b1;
        large_package <= 1'b1;
        want_debug <= 1'b1;
        #1;
        chk(debug_active, 1'b0);
        chk(fetch_enable, 1'b0);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        strap(1'b1, 1'b1);
        leave();
        $display("corner test done");
    endtask
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        seed = $urandom(16188);
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        strap(1'b1, 1'b1);
        leave();
        strap(1'b0, 1'b1);
        strap(1'b1, 1'b0);
        repeat (40) begin
            @(posedge clk);
            stop_mode <= 1'($urandom);
            wdt_enable <= 1'($urandom);
            dbg_exec_req <= 1'($urandom);
            halt_enter <= 1'b1;
            @(posedge clk);
            halt_enter <= 1'b0;
            breakpoint_done <= 1'b1;
            #1;
            chk(halt_active, 1'b1);
            @(posedge clk);
            breakpoint_done <= 1'b0;
            #1;
            chk(debug_active, 1'b1);
            chk(halt_active, 1'b0);
            chk(fetch_enable, exp_fetch(1'b1, 1'b0, dbg_exec_req));
            chk(wdt_refresh, wdt_enable);
            chk(sysclk_enable, !stop_mode);
            chk(periph_enable, !stop_mode);
            leave();
        end
        $display("breakpoint test done");
        corners();
        final_report();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report();
    end
endmodule // tb_debug_mode_entry_control
`default_nettype wire
